// ==== hw/rfs_supervisor.sv ====
// rfs_supervisor: fault supervision and power-stage ordering for a step-down regulator.
// assumes analog comparators on cmp_in, gate drivers on drv_q, software on APB.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module rfs_supervisor #(
  parameter int unsigned PG_DELAY_CYC    = rfs_pkg::PG_DELAY_CYC,
  parameter int unsigned AVG_TIMEOUT_CYC = rfs_pkg::AVG_TIMEOUT_CYC
) (
  input  wire logic             pclk,                  // system clock, 100 MHz
  input  wire logic             presetn,               // async reset, active low
  input  wire logic             psel,                  // apb select
  input  wire logic             penable,               // apb access phase
  input  wire logic             pwrite,                // apb write
  input  wire logic [7:0]       paddr,                 // apb byte address
  input  wire logic [31:0]      pwdata,                // apb write data
  output logic      [31:0]      prdata,                // apb read data
  output logic                  pready,                // apb ready
  output logic                  pslverr,               // apb error on unmapped
  input  wire rfs_pkg::rfs_cmp_t cmp_in,               // async comparator levels
  output rfs_pkg::rfs_drv_t     drv_q,                 // power stage orders
  output logic                  regulation_ok_out,     // open-drain data, always 0
  output logic                  regulation_ok_oe_n,    // low while pulling pin low
  output logic                  thermal_throttle_out,  // open-drain data, always 0
  output logic                  thermal_throttle_oe_n, // low while pulling pin low
  output logic                  irq                    // level interrupt
);

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  rfs_pkg::rfs_cmp_t cs;

  rfs_sync2 #(.W(rfs_pkg::CMP_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (cmp_in),
    .q       (cs)
  );

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  rfs_pkg::rfs_state_t          state_q, state_d;
  logic [rfs_pkg::EV_W-1:0]     status_q, mask_q, ev, cond, cond_prev_q;
  logic                         force_off_q;
  logic                         latch_q;
  logic                         skip_q;
  logic [rfs_pkg::TMR_W-1:0]    pg_cnt_q, avg_cnt_q;
  logic [rfs_pkg::BLANK_W-1:0]  blank_cnt_q;
  logic                         en, blanked, masked;
  logic                         ovf_trip, ovv_trip, uv_trip, otp_trip, avg_trip;
  logic                         toggle, pg_done, switching;
  logic                         wr_acc, rd_setup, addr_ok;
  logic [rfs_pkg::EV_W-1:0]     w1c;
  rfs_pkg::rfs_drv_t            drv_d;

  assign en        = cs.core_enable_in & ~force_off_q;
  assign switching = (state_q == rfs_pkg::ST_START) | (state_q == rfs_pkg::ST_PGW)
                   | (state_q == rfs_pkg::ST_RUN);
  // a disable or a supply dip is the restart toggle
  assign toggle    = ~cs.core_enable_in | cs.supply_low;

  // ----------------------------------------------------------------
  // fault detection
  // ----------------------------------------------------------------
  // blanking counter reloads for the whole ramp and runs out after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_cnt_q <= '0;
    end else if (cs.ref_ramping) begin
      blank_cnt_q <= rfs_pkg::BLANK_W'(rfs_pkg::BLANK_CYC);
    end else if (blank_cnt_q != '0) begin
      blank_cnt_q <= blank_cnt_q - 1'b1;
    end
  end

  assign blanked = cs.ref_ramping | (blank_cnt_q != '0);
  // window checks only count once regulation ok has been released
  assign masked  = blanked | (state_q != rfs_pkg::ST_RUN);

  assign ovf_trip = cs.vout_ovf;
  assign ovv_trip = cs.vout_ovv & ~masked;
  assign uv_trip  = cs.vout_uv & ~masked & ~cs.ref_below_300;
  assign otp_trip = cs.die_hot & ~masked;

  // average current timer: one unbroken over-limit interval must outlast the timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_cnt_q <= '0;
    end else if (!cs.load_current_report_over || !switching) begin
      avg_cnt_q <= '0;
    end else if (avg_cnt_q != rfs_pkg::TMR_W'(AVG_TIMEOUT_CYC)) begin
      avg_cnt_q <= avg_cnt_q + 1'b1;
    end
  end

  assign avg_trip = cs.load_current_report_over & switching
                  & (avg_cnt_q == rfs_pkg::TMR_W'(AVG_TIMEOUT_CYC));

  // power good delay timer, runs only while waiting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pg_cnt_q <= '0;
    end else if (state_q != rfs_pkg::ST_PGW) begin
      pg_cnt_q <= '0;
    end else if (!pg_done) begin
      pg_cnt_q <= pg_cnt_q + 1'b1;
    end
  end

  assign pg_done = (pg_cnt_q == rfs_pkg::TMR_W'(PG_DELAY_CYC));

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      rfs_pkg::ST_IDLE: begin
        if (en) begin
          state_d = rfs_pkg::ST_START;
        end
      end
      rfs_pkg::ST_START: begin
        if (!en) begin
          state_d = rfs_pkg::ST_DISCH;
        end else if (cs.ref_reached) begin
          state_d = rfs_pkg::ST_PGW;
        end
      end
      rfs_pkg::ST_PGW: begin
        if (!en) begin
          state_d = rfs_pkg::ST_DISCH;
        end else if (pg_done) begin
          state_d = rfs_pkg::ST_RUN;
        end
      end
      rfs_pkg::ST_RUN: begin
        if (!en || ovv_trip || uv_trip || otp_trip) begin
          state_d = rfs_pkg::ST_DISCH;
        end
      end
      rfs_pkg::ST_DISCH: begin
        if (cs.vout_low) begin
          state_d = rfs_pkg::ST_LSH;
        end
      end
      rfs_pkg::ST_LSH: begin
        if (!latch_q && en) begin
          state_d = rfs_pkg::ST_START;
        end
      end
      rfs_pkg::ST_HIZ: begin
        if (!latch_q) begin
          state_d = rfs_pkg::ST_IDLE;
        end
      end
      rfs_pkg::ST_SUPLO: begin
        if (!cs.supply_low) begin
          state_d = rfs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = rfs_pkg::ST_IDLE;
      end
    endcase
    // faults that override every sequencer step, highest first
    if (cs.supply_low) begin
      state_d = rfs_pkg::ST_SUPLO;
    end else if (ovf_trip) begin
      state_d = rfs_pkg::ST_LSH;
    end else if (avg_trip) begin
      state_d = rfs_pkg::ST_HIZ;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rfs_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // fault latch: a new trip wins over a toggle in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
    end else if (ovf_trip || avg_trip || (state_q == rfs_pkg::ST_RUN
                 && (ovv_trip || uv_trip || otp_trip))) begin
      latch_q <= 1'b1;
    end else if (toggle) begin
      latch_q <= 1'b0;
    end
  end

  // valley limit: sampled while the low side conducts, clears with the comparator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
    end else if (drv_q.ls_on && cs.valley_limit) begin
      skip_q <= 1'b1;
    end else if (!cs.valley_limit) begin
      skip_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power stage and pins
  // ----------------------------------------------------------------
  // decoded from the next state so a fault reaches the gates one edge sooner
  always_comb begin
    drv_d = rfs_pkg::DRV_OFF;
    case (state_d)
      rfs_pkg::ST_START, rfs_pkg::ST_PGW, rfs_pkg::ST_RUN: begin
        drv_d.hs_on = cs.pwm_on_req & ~skip_q;
        drv_d.ls_on = ~(cs.pwm_on_req & ~skip_q);
      end
      rfs_pkg::ST_DISCH: begin
        drv_d.discharge_on = 1'b1;
      end
      rfs_pkg::ST_LSH, rfs_pkg::ST_SUPLO: begin
        drv_d.ls_on = 1'b1;
      end
      rfs_pkg::ST_HIZ: begin
        drv_d.hiz          = 1'b1;
        drv_d.discharge_on = 1'b1;
      end
      default: begin
        drv_d = rfs_pkg::DRV_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_q <= rfs_pkg::DRV_OFF;
    end else begin
      drv_q <= drv_d;
    end
  end

  // open-drain pins: data stays 0, the enable decides
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulation_ok_out     <= 1'b0;
      thermal_throttle_out  <= 1'b0;
      regulation_ok_oe_n    <= 1'b0;
      thermal_throttle_oe_n <= 1'b1;
    end else begin
      regulation_ok_out     <= 1'b0;
      thermal_throttle_out  <= 1'b0;
      regulation_ok_oe_n    <= (state_d == rfs_pkg::ST_RUN) & en
                             & ~cs.vout_uv & ~cs.vout_ovv;
      thermal_throttle_oe_n <= ~cs.thermal_sense_in_below;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    cond = '0;
    cond[rfs_pkg::EV_OVF]   = ovf_trip;
    cond[rfs_pkg::EV_OVV]   = ovv_trip;
    cond[rfs_pkg::EV_UV]    = uv_trip;
    cond[rfs_pkg::EV_AVG]   = avg_trip;
    cond[rfs_pkg::EV_OTP]   = otp_trip;
    cond[rfs_pkg::EV_SUPLO] = cs.supply_low;
    cond[rfs_pkg::EV_VALL]  = cs.valley_limit;
    cond[rfs_pkg::EV_THROT] = cs.thermal_sense_in_below;
  end

  assign ev = cond & ~cond_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_prev_q <= '0;
    end else begin
      cond_prev_q <= cond;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait states, data prepared in the setup cycle
  // ----------------------------------------------------------------
  assign addr_ok  = (paddr == rfs_pkg::OFF_STATUS) | (paddr == rfs_pkg::OFF_MASK)
                  | (paddr == rfs_pkg::OFF_CTRL) | (paddr == rfs_pkg::OFF_STATE);
  assign rd_setup = psel & ~penable;
  assign wr_acc   = psel & penable & pready & pwrite & addr_ok;
  assign w1c      = (wr_acc && paddr == rfs_pkg::OFF_STATUS)
                  ? pwdata[rfs_pkg::EV_W-1:0] : '0;

  // set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~w1c) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q      <= rfs_pkg::MASK_RST;
      force_off_q <= rfs_pkg::CTRL_RST;
    end else if (wr_acc && paddr == rfs_pkg::OFF_MASK) begin
      mask_q <= pwdata[rfs_pkg::EV_W-1:0];
    end else if (wr_acc && paddr == rfs_pkg::OFF_CTRL) begin
      force_off_q <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & ~addr_ok;
      prdata  <= '0;
      if (rd_setup && !pwrite) begin
        case (paddr)
          rfs_pkg::OFF_STATUS: prdata <= {24'h000000, status_q};
          rfs_pkg::OFF_MASK:   prdata <= {24'h000000, mask_q};
          rfs_pkg::OFF_CTRL:   prdata <= {31'h00000000, force_off_q};
          rfs_pkg::OFF_STATE:  prdata <= {20'h00000, cs.throttle_pin, cs.regok_pin,
                                          latch_q, skip_q, state_q};
          default:             prdata <= '0;
        endcase
      end
    end
  end

endmodule : rfs_supervisor

// ==== hw/rfs_pkg.sv ====
// rfs_pkg: shared constants and carrier types for the regulator fault supervisor.
// assumes a single 100 MHz system clock and a 32-bit APB register port.
package rfs_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned PG_DELAY_MS    = 4;
  localparam int unsigned AVG_TIMEOUT_MS = 4;
  localparam int unsigned BLANK_US       = 30;
  localparam int unsigned PG_DELAY_CYC   = PG_DELAY_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned AVG_TIMEOUT_CYC = AVG_TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned BLANK_CYC      = BLANK_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned TMR_W          = 20;
  localparam int unsigned BLANK_W        = 12;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_STATE  = 8'h0C;
  localparam int unsigned EV_W      = 8;
  localparam logic [EV_W-1:0] MASK_RST = 8'h00;
  localparam logic            CTRL_RST = 1'b0;

  // event bit positions in status and mask
  localparam int unsigned EV_OVF   = 0;
  localparam int unsigned EV_OVV   = 1;
  localparam int unsigned EV_UV    = 2;
  localparam int unsigned EV_AVG   = 3;
  localparam int unsigned EV_OTP   = 4;
  localparam int unsigned EV_SUPLO = 5;
  localparam int unsigned EV_VALL  = 6;
  localparam int unsigned EV_THROT = 7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_START = 8'h02,
    ST_PGW   = 8'h04,
    ST_RUN   = 8'h08,
    ST_DISCH = 8'h10,
    ST_LSH   = 8'h20,
    ST_HIZ   = 8'h40,
    ST_SUPLO = 8'h80
  } rfs_state_t;

  // comparator and pin indications, all asynchronous to pclk
  typedef struct packed {
    logic core_enable_in;  // enable pin
    logic ref_reached;     // reference at its programmed setpoint
    logic ref_ramping;     // setpoint transition in progress
    logic ref_below_300;   // programmed setpoint under 300 mV
    logic pwm_on_req;      // on-time request from the loop
    logic vout_uv;         // output more than 300 mV under reference
    logic vout_ovv;        // output more than 200 mV over reference
    logic vout_ovf;        // output at fixed 1.55 V limit
    logic vout_low;        // output under about 100 mV
    logic load_current_report_over;       // monitor feedback current over its limit
    logic thermal_sense_in_below;     // thermal sense under threshold (hysteresis in analog)
    logic die_hot;         // die over 150 C
    logic supply_low;      // logic supply under 3.9 V, released over 4.4 V
    logic valley_limit;    // valley current limit comparator
    logic regok_pin;       // level read back from regulation ok pin
    logic throttle_pin;    // level read back from throttle pin
  } rfs_cmp_t;

  localparam int unsigned CMP_W = $bits(rfs_cmp_t);

  typedef struct packed {
    logic hs_on;         // high-side gate on
    logic ls_on;         // low-side gate on
    logic hiz;           // both gate drivers high impedance
    logic discharge_on;  // internal discharge path on
  } rfs_drv_t;

  localparam rfs_drv_t DRV_OFF = '{hs_on: 1'b0, ls_on: 1'b0, hiz: 1'b0, discharge_on: 1'b0};

endpackage : rfs_pkg

// ==== hw/rfs_sync2.sv ====
// rfs_sync2: two flip-flop synchroniser for a bundle of independent levels.
// assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/1ps
module rfs_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,     // system clock
  input  wire logic         presetn,  // async reset, active low
  input  wire logic [W-1:0] d,        // asynchronous levels
  output logic      [W-1:0] q         // synchronised levels
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : rfs_sync2

// ==== tb/rfs_supervisor_sva.sv ====
// rfs_supervisor_sva: port-level properties of the fault supervisor.
// assumes inputs reach outputs 3 edges later (2 sync flops, 1 output flop).
`timescale 1ns/1ps
module rfs_supervisor_sva #(
  parameter int unsigned PG_DELAY_CYC = rfs_pkg::PG_DELAY_CYC
) (
  input wire logic              pclk,                  // system clock
  input wire logic              presetn,               // async reset, active low
  input wire logic              psel,                  // apb select
  input wire logic              penable,               // apb access
  input wire logic              pready,                // apb ready
  input wire rfs_pkg::rfs_cmp_t cmp_in,                // comparator levels
  input wire rfs_pkg::rfs_drv_t drv_q,                 // power stage orders
  input wire logic              regulation_ok_oe_n,    // low pulls pin low
  input wire logic              thermal_throttle_oe_n  // low pulls pin low
);
  // ------
  // helper
  // ------
  // counts raw settled cycles; the design sees them later, so it can only be larger
  logic [19:0] pg_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pg_cnt_q <= 20'h0;
    else if (!(cmp_in.core_enable_in && cmp_in.ref_reached)) pg_cnt_q <= 20'h0;
    else if (pg_cnt_q < PG_DELAY_CYC) pg_cnt_q <= pg_cnt_q + 20'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // checks
  // ------
  AST_REGOK_EN: assert property (!cmp_in.core_enable_in |-> ##3 !regulation_ok_oe_n)
    else $error("regulation ok released while disabled");
  AST_REGOK_OVV: assert property (cmp_in.vout_ovv |-> ##3 !regulation_ok_oe_n)
    else $error("regulation ok released during overvoltage");
  AST_PG_DELAY: assert property ($rose(regulation_ok_oe_n) |-> pg_cnt_q >= PG_DELAY_CYC)
    else $error("regulation ok released early");
  AST_THR_LO: assert property (cmp_in.thermal_sense_in_below |-> ##3 !thermal_throttle_oe_n)
    else $error("throttle not pulled low");
  AST_THR_HI: assert property (!cmp_in.thermal_sense_in_below |-> ##3 thermal_throttle_oe_n)
    else $error("throttle not released");
  AST_OVF: assert property (cmp_in.vout_ovf |-> ##3 (drv_q.ls_on && !drv_q.hs_on))
    else $error("fixed overvoltage response wrong");
  AST_SUPLO: assert property (cmp_in.supply_low |-> ##3 (drv_q.ls_on && !drv_q.hs_on))
    else $error("supply low response wrong");
  AST_HIZ: assert property (drv_q.hiz |-> drv_q.discharge_on && !drv_q.hs_on)
    else $error("high impedance without discharge");
  AST_DISCH: assert property (drv_q.discharge_on |-> !drv_q.hs_on && !drv_q.ls_on)
    else $error("switch on during discharge");
  AST_LATCH: assert property ($fell(drv_q.hiz) |->
    !$past(cmp_in.core_enable_in, 3) || $past(cmp_in.supply_low, 3))
    else $error("latched fault left without toggle");
  AST_RAMP: assert property ($rose(drv_q.discharge_on) && !drv_q.hiz &&
    $past(cmp_in.core_enable_in, 3) |-> !$past(cmp_in.ref_ramping, 3))
    else $error("fault taken during ramp");
  AST_APB_RDY: assert property (psel && !penable |=> pready)
    else $error("apb access not ready");
  COV_HIZ: cover property (drv_q.hiz);
  COV_PG: cover property ($rose(regulation_ok_oe_n));
  COV_SOFT: cover property (drv_q.discharge_on ##1 !drv_q.discharge_on && drv_q.ls_on);
endmodule : rfs_supervisor_sva

// ==== tb/rfs_stage_model.sv ====
// rfs_stage_model: output node of the power stage, seen as a charge level.
// assumes drive orders from the supervisor; reports output under 100 mV.
`timescale 1ns/1ps
module rfs_stage_model #(
  parameter int unsigned FULL = 15
) (
  input wire logic              pclk,     // system clock
  input wire logic              presetn,  // async reset, active low
  input wire rfs_pkg::rfs_drv_t drv,      // power stage orders
  output logic                  vout_low  // output near ground
);
  // slow on purpose: discharge takes FULL cycles, so the order waits for it
  logic [7:0] lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lvl_q <= 8'h0;
    else if (drv.hs_on && lvl_q < FULL) lvl_q <= lvl_q + 8'h1;
    else if ((drv.discharge_on || drv.ls_on) && lvl_q != 8'h0) lvl_q <= lvl_q - 8'h1;
  end
  assign vout_low = (lvl_q == 8'h0);
endmodule : rfs_stage_model

// ==== tb/rfs_supervisor_tb_top.sv ====
// rfs_supervisor_tb_top: directed scenarios for the fault supervisor.
// assumes the stage model closes the output loop and pins are pulled up.
`timescale 1ns/1ps
module rfs_supervisor_tb_top;
  localparam int unsigned PGD = 50;
  localparam int unsigned AVG = 20;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic              vlow, rok_out, rok_oe_n, thr_out, thr_oe_n, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  rfs_pkg::rfs_cmp_t cmp, cmp_w;
  rfs_pkg::rfs_drv_t drv;
  int                num_errors, check_count, n;
  always_comb begin
    cmp_w = cmp;
    cmp_w.vout_low = vlow;
    cmp_w.regok_pin = rok_oe_n;
    cmp_w.throttle_pin = thr_oe_n;
  end
  rfs_supervisor #(.PG_DELAY_CYC(PGD), .AVG_TIMEOUT_CYC(AVG)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_in(cmp_w), .drv_q(drv), .regulation_ok_out(rok_out),
    .regulation_ok_oe_n(rok_oe_n), .thermal_throttle_out(thr_out),
    .thermal_throttle_oe_n(thr_oe_n), .irq(irq));
  rfs_stage_model stage_u (.pclk(pclk), .presetn(presetn), .drv(drv), .vout_low(vlow));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // ------
  // tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge, so back-to-back calls never drive psel twice in one step
    @(posedge pclk);
  endtask : apb
  // enable toggle restarts; n counts cycles until regulation ok is released
  task automatic start();
    cmp.core_enable_in <= 1'h0;
    cyc(30);
    cmp.core_enable_in <= 1'h1;
    cmp.ref_reached <= 1'h1;
    cmp.pwm_on_req <= 1'h1;
    for (n = 0; n < 400 && rok_oe_n !== 1'h1; n++) @(posedge pclk);
  endtask : start
  task automatic t_reset();
    check(drv, 4'h0);
    check(rok_oe_n, 1'h0);
    check(thr_oe_n, 1'h1);
    apb(1'h0, rfs_pkg::OFF_MASK, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    check(err, 1'h1);
    check({rok_out, thr_out}, 2'h0);
    apb(1'h1, rfs_pkg::OFF_CTRL, 32'h1);
    apb(1'h0, rfs_pkg::OFF_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, rfs_pkg::OFF_CTRL, 32'h0);
  endtask : t_reset
  task automatic t_pg();
    start();
    check(n >= PGD && n <= PGD + 8, 1'h1);
    apb(1'h0, rfs_pkg::OFF_STATE, 32'h0);
    check(rd[7:0], 8'h08);
  endtask : t_pg
  task automatic t_throt();
    cmp.thermal_sense_in_below <= 1'h1;
    apb(1'h1, rfs_pkg::OFF_MASK, 32'h80);
    cyc(3);
    check(thr_oe_n, 1'h0);
    check(irq, 1'h1);
    cmp.thermal_sense_in_below <= 1'h0;
    apb(1'h1, rfs_pkg::OFF_STATUS, 32'h80);
    cyc(3);
    check(irq, 1'h0);
    check(thr_oe_n, 1'h1);
  endtask : t_throt
  task automatic t_valley();
    cmp.pwm_on_req <= 1'h0;
    cyc(4);
    cmp.valley_limit <= 1'h1;
    cyc(4);
    cmp.pwm_on_req <= 1'h1;
    cyc(6);
    check(drv.hs_on, 1'h0);
    cmp.valley_limit <= 1'h0;
    cyc(6);
    check(drv.hs_on, 1'h1);
  endtask : t_valley
  task automatic t_ovv();
    cmp.vout_ovv <= 1'h1;
    cyc(4);
    check(rok_oe_n, 1'h0);
    check(drv, 4'h1);
    cmp.vout_ovv <= 1'h0;
    cyc(40);
    check(drv, 4'h4);
    apb(1'h0, rfs_pkg::OFF_STATUS, 32'h0);
    check(rd[rfs_pkg::EV_OVV], 1'h1);
    start();
    check(drv.hs_on, 1'h1);
  endtask : t_ovv
  task automatic t_avg();
    repeat (3) begin
      cmp.load_current_report_over <= 1'h1;
      cyc(AVG - 4);
      cmp.load_current_report_over <= 1'h0;
      cyc(1);
    end
    cyc(4);
    check(drv.hiz, 1'h0);
    cmp.load_current_report_over <= 1'h1;
    cyc(AVG + 6);
    cmp.load_current_report_over <= 1'h0;
    cyc(8);
    check(drv, 4'h3);
    start();
  endtask : t_avg
  task automatic t_uv();
    cmp.ref_below_300 <= 1'h1;
    cmp.vout_uv <= 1'h1;
    cyc(10);
    check(drv.discharge_on, 1'h0);
    check(rok_oe_n, 1'h0);
    cmp.vout_uv <= 1'h0;
    cmp.ref_below_300 <= 1'h0;
    cyc(5);
    check(rok_oe_n, 1'h1);
  endtask : t_uv
  // uv held through a ramp may only trip once the blanking count has run out
  task automatic t_mask();
    cmp.ref_ramping <= 1'h1;
    cmp.vout_uv <= 1'h1;
    cyc(10);
    check(drv.discharge_on, 1'h0);
    cmp.ref_ramping <= 1'h0;
    cyc(rfs_pkg::BLANK_CYC - 10);
    check(drv.discharge_on, 1'h0);
    cyc(40);
    check(drv, 4'h4);
    cmp.vout_uv <= 1'h0;
    start();
    cmp.die_hot <= 1'h1;
    cyc(40);
    check(drv, 4'h4);
    cmp.die_hot <= 1'h0;
  endtask : t_mask
  task automatic t_stop();
    cmp.vout_ovf <= 1'h1;
    cyc(4);
    cmp.vout_ovf <= 1'h0;
    cyc(6);
    check(drv, 4'h4);
    cmp.supply_low <= 1'h1;
    cyc(4);
    check(drv, 4'h4);
    cmp.supply_low <= 1'h0;
    cyc(5);
    apb(1'h0, rfs_pkg::OFF_STATE, 32'h0);
    // supply back with enable high: latch gone, sequence already waiting for power good
    check(rd[9:0], 10'h004);
  endtask : t_stop
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    num_errors = 0;
    check_count = 0;
    cmp = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    cyc(3);
    presetn <= 1'h1;
    cyc(1);
    t_reset();
    t_pg();
    t_throt();
    t_valley();
    t_ovv();
    t_avg();
    t_uv();
    t_mask();
    t_stop();
    stop_test();
  end
endmodule : rfs_supervisor_tb_top
bind rfs_supervisor rfs_supervisor_sva #(.PG_DELAY_CYC(PG_DELAY_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .cmp_in(cmp_in), .drv_q(drv_q), .regulation_ok_oe_n(regulation_ok_oe_n),
  .thermal_throttle_oe_n(thermal_throttle_oe_n));
